// ===== logic/ewic_ctrl.sv
// edge/wakeup interrupt controller with exception entry sequencer
// assumes an ahb-lite master, synchronous pins and a cpu core that
// reports instruction completion and accepts stack and fetch strobes
//
// Summary of operation
// - wake pin falling edge sets its flag
// - wake enable bit gates all wake flags
// - mask bit set blocks acceptance, requests stay
// - all wake sources share vector nine
// - polarity bit selects rising or falling edge
// - selected edge sets pin request flag
// - per pin enable bit blocks its request
// - pins use vectors four to eight, pin0 first
// - peripheral requests set flags in two registers
// - per peripheral enable bit blocks its request
// - peripheral vectors span ten to twenty
// - highest priority pending request is selected
// - accept only while mask bit is zero
// - stack next pc and ccr after instruction
// - accepting sets the mask bit
// - fetch vector then start the handler
// - entry state counts four, two, four, four
// - colliding request still runs after clear
// - word stack address even, restore even byte
// - pin function switch may set pin flag
// - wake function switch while low sets flag
// - clear right after function write ignored
// - acceptance leaves request flag set
// - flags only clear on written zero
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ewic_ctrl
   import ewic_pkg::*;
#(
   parameter int PC_W = 16
)(
   input  wire logic               CLK,
   input  wire logic               RST_B,
   input  wire logic               HSEL,
   input  wire logic [31:0]        HADDR,
   input  wire logic [1:0]         HTRANS,
   input  wire logic               HWRITE,
   input  wire logic [2:0]         HSIZE,
   input  wire logic [31:0]        HWDATA,
   input  wire logic               HREADY,
   output logic      [31:0]        HRDATA,
   output logic                    HREADYOUT,
   output logic                    HRESP,
   input  wire logic [NUM_WAKE-1:0]   WAKE_PIN,
   input  wire logic [NUM_PIN-1:0]    EDGE_REQUEST_PIN,
   input  wire logic [NUM_PERIPH-1:0] PERIPH_REQ,
   input  wire logic               INSN_DONE,
   input  wire logic [PC_W-1:0]    NEXT_PC,
   input  wire logic [PC_W-1:0]    STACK_PTR,
   input  wire logic [PC_W-1:0]    VEC_DATA,
   input  wire logic               RETURN_STB,
   input  wire logic [15:0]        RETURN_CCR_WORD,
   output logic                    MASK,
   output logic                    EXC_BUSY,
   output logic                    STACK_WE,
   output logic      [PC_W-1:0]    STACK_ADDR,
   output logic      [PC_W-1:0]    STACK_WDATA,
   output logic                    VEC_RD,
   output logic      [PC_W-1:0]    VEC_ADDR,
   output logic                    IFETCH,
   output logic                    HANDLER_START,
   output logic      [PC_W-1:0]    HANDLER_PC
);

   // ****************************************************************
   // elaboration checks and helpers
   // ****************************************************************
   if (PC_W < 16)
   begin : g_bad_pc_w
      $error("PC_W must be at least 16");
   end

   function automatic int periph_vec(input int idx);
      return VEC_PERIPH_BASE + (idx * VEC_PERIPH_SPAN) / NUM_PERIPH;
   endfunction : periph_vec

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [7:0]            dp_ofs;
   logic                  dp_write;
   logic                  dp_first;
   logic                  wr_fire;
   logic                  pf_recent;
   logic                  clr_ok;
   logic [7:0]            wake_flag;
   logic [NUM_PIN-1:0]    pin_flag;
   logic [NUM_PERIPH-1:0] periph_flag;
   logic [NUM_PIN-1:0]    pin_en;
   logic                  wake_en;
   logic [NUM_PERIPH-1:0] periph_en;
   logic [NUM_PIN-1:0]    edge_pol;
   logic [7:0]            pfn_one;
   logic [7:0]            pfn_two;
   logic [7:0]            pfn_five;
   logic [NUM_WAKE-1:0]   wake_eff;
   logic [NUM_WAKE-1:0]   wake_prev;
   logic [NUM_WAKE-1:0]   wake_set;
   logic [NUM_PIN-1:0]    pin_eff;
   logic [NUM_PIN-1:0]    pin_prev;
   logic [NUM_PIN-1:0]    pin_set;
   logic [VEC_MAX:0]      vreq;
   logic [4:0]            sel_vec;
   logic                  sel_valid;
   logic                  accept;
   logic [31:0]           rd_mux;
   ewic_state_t           state;
   logic [2:0]            cnt;
   logic                  ccr_saved;

   // ****************************************************************
   // ahb-lite slave: one wait state per transfer, always okay
   // ****************************************************************
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         dp_first <= 1'b0;
         dp_write <= 1'b0;
         dp_ofs   <= 8'h00;
      end
      else if (HSEL && HTRANS[1] && HREADY)
      begin
         dp_first <= 1'b1;
         dp_write <= HWRITE;
         dp_ofs   <= HADDR[7:0];
      end
      else
      begin
         dp_first <= 1'b0;
      end
   end

   assign HREADYOUT = ~dp_first;
   assign HRESP     = 1'b0;
   assign wr_fire   = dp_first & dp_write;
   assign clr_ok    = ~pf_recent;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (dp_ofs)
         OFS_WAKE_FLAG: rd_mux[7:0] = wake_flag;
         OFS_REQ_ONE:
         begin
            rd_mux[NUM_PIN-1:0] = pin_flag;
            rd_mux[PERIPH_LSB_ONE +: PERIPH_SPLIT] =
               periph_flag[PERIPH_SPLIT-1:0];
         end
         OFS_REQ_TWO:
            rd_mux[PERIPH_SPLIT-1:0] =
               periph_flag[NUM_PERIPH-1:PERIPH_SPLIT];
         OFS_EN_ONE:
         begin
            rd_mux[NUM_PIN-1:0] = pin_en;
            rd_mux[WAKE_EN_BIT] = wake_en;
            rd_mux[PERIPH_LSB_ONE +: PERIPH_SPLIT] =
               periph_en[PERIPH_SPLIT-1:0];
         end
         OFS_EN_TWO:
            rd_mux[PERIPH_SPLIT-1:0] =
               periph_en[NUM_PERIPH-1:PERIPH_SPLIT];
         OFS_EDGE_SEL:  rd_mux[NUM_PIN-1:0] = edge_pol;
         OFS_PFN_ONE:   rd_mux[7:0] = pfn_one;
         OFS_PFN_TWO:   rd_mux[7:0] = pfn_two;
         OFS_PFN_FIVE:  rd_mux[7:0] = pfn_five;
         OFS_CCR:       rd_mux[CCR_MASK_BIT] = MASK;
         OFS_STATUS:
         begin
            rd_mux[4:0]  = sel_vec;
            rd_mux[8]    = sel_valid;
            rd_mux[21:16] = state;
         end
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         HRDATA <= 32'h0000_0000;
      else if (dp_first && !dp_write)
         HRDATA <= rd_mux;
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pin_en    <= '0;
         wake_en   <= 1'b0;
         periph_en <= '0;
         edge_pol  <= '0;
         pfn_one   <= 8'h00;
         pfn_two   <= 8'h00;
         pfn_five  <= 8'h00;
      end
      else if (wr_fire)
      begin
         unique case (dp_ofs)
            OFS_EN_ONE:
            begin
               pin_en  <= HWDATA[NUM_PIN-1:0];
               wake_en <= HWDATA[WAKE_EN_BIT];
               periph_en[PERIPH_SPLIT-1:0] <=
                  HWDATA[PERIPH_LSB_ONE +: PERIPH_SPLIT];
            end
            OFS_EN_TWO:
               periph_en[NUM_PERIPH-1:PERIPH_SPLIT] <=
                  HWDATA[PERIPH_SPLIT-1:0];
            OFS_EDGE_SEL: edge_pol <= HWDATA[NUM_PIN-1:0];
            OFS_PFN_ONE:  pfn_one  <= HWDATA[7:0];
            OFS_PFN_TWO:  pfn_two  <= HWDATA[7:0];
            OFS_PFN_FIVE: pfn_five <= HWDATA[7:0];
            default:      pfn_five <= pfn_five;
         endcase
      end
   end

   // flag write right after a pin function write is swallowed
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         pf_recent <= 1'b0;
      else if (wr_fire)
         pf_recent <= (dp_ofs == OFS_PFN_ONE) || (dp_ofs == OFS_PFN_TWO) ||
                      (dp_ofs == OFS_PFN_FIVE);
   end

   // ****************************************************************
   // pin edge detection
   // ****************************************************************
   // a pin not in its request function reads as high, so a function
   // switch while low looks like an edge
   genvar gi;
   for (gi = 0; gi < NUM_WAKE; gi++)
   begin : g_wake
      assign wake_eff[gi] = pfn_five[gi] ? WAKE_PIN[gi] : 1'b1;
      assign wake_set[gi] = wake_prev[gi] & ~wake_eff[gi];
   end

   for (gi = 0; gi < NUM_PIN; gi++)
   begin : g_pin
      assign pin_eff[gi] = (PIN_ON_PFN_TWO[gi] ? pfn_two[gi] : pfn_one[gi])
                           ? EDGE_REQUEST_PIN[gi] : 1'b1;
      assign pin_set[gi] = edge_pol[gi]
                           ? (~pin_prev[gi] & pin_eff[gi])
                           : (pin_prev[gi] & ~pin_eff[gi]);
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wake_prev <= '1;
         pin_prev  <= '1;
      end
      else
      begin
         wake_prev <= wake_eff;
         pin_prev  <= pin_eff;
      end
   end

   // ****************************************************************
   // request flags: set wins over a written zero
   // ****************************************************************
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         wake_flag <= FLAG_RESET;
      else if (wr_fire && clr_ok && dp_ofs == OFS_WAKE_FLAG)
         wake_flag <= (wake_flag & HWDATA[7:0]) | wake_set;
      else
         wake_flag <= wake_flag | wake_set;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         pin_flag <= '0;
      else if (wr_fire && clr_ok && dp_ofs == OFS_REQ_ONE)
         pin_flag <= (pin_flag & HWDATA[NUM_PIN-1:0]) | pin_set;
      else
         pin_flag <= pin_flag | pin_set;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         periph_flag <= '0;
      else if (wr_fire && clr_ok && dp_ofs == OFS_REQ_ONE)
         periph_flag <= PERIPH_REQ | (periph_flag &
            {{(NUM_PERIPH-PERIPH_SPLIT){1'b1}},
             HWDATA[PERIPH_LSB_ONE +: PERIPH_SPLIT]});
      else if (wr_fire && clr_ok && dp_ofs == OFS_REQ_TWO)
         periph_flag <= PERIPH_REQ | (periph_flag &
            {HWDATA[PERIPH_SPLIT-1:0], {PERIPH_SPLIT{1'b1}}});
      else
         periph_flag <= periph_flag | PERIPH_REQ;
   end

   // ****************************************************************
   // priority selection, lowest vector number wins
   // ****************************************************************
   always_comb
   begin
      vreq = '0;
      for (int i = 0; i < NUM_PIN; i++)
         vreq[VEC_PIN_BASE + i] = pin_flag[i] & pin_en[i];
      vreq[VEC_WAKE] = wake_en & (|wake_flag);
      for (int i = 0; i < NUM_PERIPH; i++)
         if (periph_flag[i] && periph_en[i])
            vreq[periph_vec(i)] = 1'b1;
   end

   always_comb
   begin
      sel_vec   = 5'h00;
      sel_valid = 1'b0;
      for (int v = VEC_MAX; v >= 0; v--)
         if (vreq[v])
         begin
            sel_vec   = 5'(v);
            sel_valid = 1'b1;
         end
   end

   assign accept = (state == ST_IDLE) && sel_valid && !MASK;

   // ****************************************************************
   // global mask bit
   // ****************************************************************
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         MASK <= CCR_MASK_RESET;
      else if (accept)
         MASK <= 1'b1;
      else if (RETURN_STB)
         MASK <= RETURN_CCR_WORD[8 + CCR_MASK_BIT];
      else if (wr_fire && dp_ofs == OFS_CCR)
         MASK <= HWDATA[CCR_MASK_BIT];
   end

   // ****************************************************************
   // exception entry sequencer
   // ****************************************************************
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state <= ST_IDLE;
         cnt   <= 3'h0;
      end
      else
      begin
         cnt <= cnt + 3'h1;
         unique case (state)
            ST_IDLE:
               if (accept)
                  state <= ST_WAIT;
            ST_WAIT:
            begin
               cnt <= 3'h0;
               if (INSN_DONE)
                  state <= ST_STACK;
            end
            ST_STACK:
               if (cnt == STACK_LAST)
               begin
                  cnt   <= 3'h0;
                  state <= ST_VFETCH;
               end
            ST_VFETCH:
               if (cnt == VFETCH_LAST)
               begin
                  cnt   <= 3'h0;
                  state <= ST_IFETCH;
               end
            ST_IFETCH:
               if (cnt == IFETCH_LAST)
               begin
                  cnt   <= 3'h0;
                  state <= ST_INTPRC;
               end
            ST_INTPRC:
               if (cnt == INTPRC_LAST)
                  state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ccr_saved <= 1'b0;
         VEC_ADDR  <= '0;
      end
      else if (accept)
      begin
         ccr_saved <= MASK;
         VEC_ADDR  <= PC_W'({sel_vec, 1'b0});
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         STACK_ADDR  <= '0;
         STACK_WDATA <= '0;
      end
      else if (state == ST_WAIT && INSN_DONE)
      begin
         STACK_ADDR  <= {STACK_PTR[PC_W-1:1], 1'b0} - PC_W'(2);
         STACK_WDATA <= NEXT_PC;
      end
      else if (state == ST_STACK && cnt == 3'h1)
      begin
         STACK_ADDR  <= STACK_ADDR - PC_W'(2);
         STACK_WDATA <= PC_W'({2{ccr_saved, 7'h00}});
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         HANDLER_PC    <= '0;
         HANDLER_START <= 1'b0;
      end
      else
      begin
         if (state == ST_VFETCH && cnt == VFETCH_LAST)
            HANDLER_PC <= VEC_DATA;
         HANDLER_START <= (state == ST_INTPRC) && (cnt == INTPRC_LAST);
      end
   end

   assign EXC_BUSY = (state != ST_IDLE);
   assign STACK_WE = (state == ST_STACK) && !cnt[0];
   assign VEC_RD   = (state == ST_VFETCH);
   assign IFETCH   = (state == ST_IFETCH);

endmodule : ewic_ctrl

`default_nettype wire

// ===== logic/ewic_pkg.sv
// constants, register map and types of the edge/wakeup interrupt controller
// assumes one 100 MHz clock; one cpu state equals one clock cycle
package ewic_pkg;

   // ****************************************************************
   // source counts
   // ****************************************************************
   localparam int NUM_WAKE   = 8;
   localparam int NUM_PIN    = 5;
   localparam int NUM_PERIPH = 20;
   localparam int PERIPH_SPLIT = 10;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFS_WAKE_FLAG = 8'h00;
   localparam logic [7:0] OFS_REQ_ONE   = 8'h04;
   localparam logic [7:0] OFS_REQ_TWO   = 8'h08;
   localparam logic [7:0] OFS_EN_ONE    = 8'h0c;
   localparam logic [7:0] OFS_EN_TWO    = 8'h10;
   localparam logic [7:0] OFS_EDGE_SEL  = 8'h14;
   localparam logic [7:0] OFS_PFN_ONE   = 8'h18;
   localparam logic [7:0] OFS_PFN_TWO   = 8'h1c;
   localparam logic [7:0] OFS_PFN_FIVE  = 8'h20;
   localparam logic [7:0] OFS_CCR       = 8'h24;
   localparam logic [7:0] OFS_STATUS    = 8'h28;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int PERIPH_LSB_ONE = 8;
   localparam int WAKE_EN_BIT    = 5;
   localparam int CCR_MASK_BIT   = 7;
   localparam logic       CCR_MASK_RESET = 1'b1;
   localparam logic [4:0] PIN_ON_PFN_TWO = 5'h11;
   localparam logic [7:0] FLAG_RESET     = 8'h00;

   // ****************************************************************
   // vector numbers
   // ****************************************************************
   localparam int VEC_PIN_BASE    = 4;
   localparam int VEC_WAKE        = 9;
   localparam int VEC_PERIPH_BASE = 10;
   localparam int VEC_PERIPH_SPAN = 11;
   localparam int VEC_MAX         = 20;

   // ****************************************************************
   // exception entry timing, in states
   // ****************************************************************
   localparam int STACK_STATES  = 4;
   localparam int VFETCH_STATES = 2;
   localparam int IFETCH_STATES = 4;
   localparam int INTPRC_STATES = 4;
   localparam logic [2:0] STACK_LAST  = 3'(STACK_STATES - 1);
   localparam logic [2:0] VFETCH_LAST = 3'(VFETCH_STATES - 1);
   localparam logic [2:0] IFETCH_LAST = 3'(IFETCH_STATES - 1);
   localparam logic [2:0] INTPRC_LAST = 3'(INTPRC_STATES - 1);

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_WAIT   = 6'h02,
      ST_STACK  = 6'h04,
      ST_VFETCH = 6'h08,
      ST_IFETCH = 6'h10,
      ST_INTPRC = 6'h20
   } ewic_state_t;

endpackage : ewic_pkg

// ===== sim/ewic_core_model.sv
// cpu core model facing the exception sequencer
// assumes one clock; ends instructions after a set delay
`timescale 1ns/1ps
`default_nettype none
module ewic_core_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        exc_busy,
   input  wire logic        stack_we,
   input  wire logic [15:0] stack_addr,
   input  wire logic [15:0] stack_wdata,
   input  wire logic        vec_rd,
   input  wire logic [15:0] vec_addr,
   input  wire logic        handler_start,
   input  wire logic [3:0]  done_dly,
   output logic             insn_done,
   output logic      [15:0] next_pc,
   output logic      [15:0] stack_ptr,
   output logic      [15:0] vec_data,
   output logic      [15:0] vec_num,
   output logic      [15:0] pc_seen,
   output logic      [4:0]  lat
);
   localparam logic [15:0] RET_PC = 16'h1234;
   localparam logic [15:0] SP     = 16'h0ff0;
   localparam logic [15:0] HBASE  = 16'h4000;
   logic [3:0] cnt;
   logic       fired;
   logic [4:0] run;
   // ********
   // core side
   // ********
   assign next_pc   = insn_done ? RET_PC : ~RET_PC;
   assign stack_ptr = insn_done ? SP : ~SP;
   assign vec_data  = vec_rd ? HBASE + vec_addr : ~(HBASE + vec_addr);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         insn_done <= 1'b0;
         cnt       <= 4'h0;
         fired     <= 1'b0;
         run       <= 5'h00;
         lat       <= 5'h00;
         vec_num   <= 16'h0000;
         pc_seen   <= 16'h0000;
      end
      else
      begin
         insn_done <= 1'b0;
         run       <= run + 5'h01;
         if (!exc_busy)
         begin
            cnt   <= 4'h0;
            fired <= 1'b0;
         end
         else if (!fired)
         begin
            cnt <= cnt + 4'h1;
            if (cnt + 4'h1 >= done_dly)
            begin
               insn_done <= 1'b1;
               fired     <= 1'b1;
            end
         end
         if (insn_done)
            run <= 5'h01;
         if (handler_start)
            lat <= run;
         if (vec_rd)
            vec_num <= vec_addr >> 1;
         if (stack_we && stack_addr == SP - 16'h0002)
            pc_seen <= stack_wdata;
      end
   end
endmodule : ewic_core_model
`default_nettype wire

// ===== sim/ewic_monitor.sv
// port checks for the interrupt controller entry sequence
// assumes binding into ewic_ctrl; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ewic_monitor
#(
   parameter int PC_W = 16
)(
   input wire logic            CLK,
   input wire logic            RST_B,
   input wire logic            MASK,
   input wire logic            EXC_BUSY,
   input wire logic            INSN_DONE,
   input wire logic            STACK_WE,
   input wire logic [PC_W-1:0] STACK_ADDR,
   input wire logic            VEC_RD,
   input wire logic [PC_W-1:0] VEC_ADDR,
   input wire logic            IFETCH,
   input wire logic            HANDLER_START,
   input wire logic            RETURN_STB,
   input wire logic [15:0]     RETURN_CCR_WORD
);
   // ********
   // checks
   // ********
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   logic ret_mask;
   assign ret_mask = RETURN_CCR_WORD[15];
   AST_MASK_ON_ACCEPT: assert property ($rose(EXC_BUSY) |-> MASK)
      else $error("mask not set on accept");
   AST_NO_ACCEPT_MASKED: assert property ($rose(EXC_BUSY) |->
      !$past(MASK)) else $error("accepted while masked");
   AST_STACK_AFTER_DONE: assert property ($rose(STACK_WE) &&
      !$past(STACK_WE, 2) |-> $past(INSN_DONE))
      else $error("stacking before instruction end");
   AST_STACK_SEQ: assert property ($rose(STACK_WE) &&
      !$past(STACK_WE, 2) |-> ##1 !STACK_WE ##1 STACK_WE ##1 !STACK_WE
      ##1 VEC_RD) else $error("stack phase length wrong");
   AST_VEC_LEN: assert property ($rose(VEC_RD) |-> VEC_RD ##1
      VEC_RD ##1 (!VEC_RD && IFETCH)) else $error("vector fetch wrong");
   AST_IFETCH_LEN: assert property ($rose(IFETCH) |->
      IFETCH[*4] ##1 !IFETCH) else $error("fetch length wrong");
   AST_START: assert property ($fell(IFETCH) |->
      !HANDLER_START[*4] ##1 HANDLER_START) else $error("start late");
   AST_EVEN_STACK: assert property (STACK_WE |-> !STACK_ADDR[0])
      else $error("odd stack address");
   AST_VEC_RANGE: assert property (VEC_RD |-> VEC_ADDR >= 8 &&
      VEC_ADDR <= 40 && !VEC_ADDR[0]) else $error("vector out of range");
   AST_MASK_RESTORE: assert property (RETURN_STB |=>
      MASK == $past(ret_mask)) else $error("mask not restored");
   cover property ($rose(HANDLER_START));
   cover property ($rose(EXC_BUSY));
   cover property (RETURN_STB);
endmodule : ewic_monitor

bind ewic_ctrl ewic_monitor #(.PC_W(PC_W)) u_ewic_monitor (
   .CLK(CLK), .RST_B(RST_B), .MASK(MASK), .EXC_BUSY(EXC_BUSY),
   .INSN_DONE(INSN_DONE), .STACK_WE(STACK_WE), .STACK_ADDR(STACK_ADDR),
   .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR), .IFETCH(IFETCH),
   .HANDLER_START(HANDLER_START), .RETURN_STB(RETURN_STB),
   .RETURN_CCR_WORD(RETURN_CCR_WORD));
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the interrupt controller
// assumes ewic_ctrl, the core model and the port checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ewic_pkg::*;
   logic        clk, rst_b, hsel, hwrite, hreadyout, insn_done, mask;
   logic        exc_busy, stack_we, vec_rd, ifetch, handler_start;
   logic        return_stb;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  wake_pin;
   logic [4:0]  edge_pin, lat;
   logic [19:0] periph_req;
   logic [15:0] next_pc, stack_ptr, vec_data, return_ccr, stack_addr;
   logic [15:0] stack_wdata, vec_addr, handler_pc, vec_num, pc_seen;
   logic [3:0]  done_dly;
   int          n_mismatch, checks_done, cyc;
   logic [7:0]  l_ofs [5] = '{OFS_REQ_ONE, OFS_REQ_ONE, OFS_REQ_ONE,
                              OFS_REQ_TWO, OFS_WAKE_FLAG};
   logic [31:0] l_flag [5] = '{32'h111, 32'h110, 32'h100, 32'h200, 32'h20};
   logic [31:0] l_clr [5] = '{~32'h1, ~32'h10, ~32'h100, ~32'h200, 32'h0};
   int          l_vec [5] = '{4, 8, 10, 20, 9};
   ewic_ctrl u_ewic_ctrl (.CLK(clk), .RST_B(rst_b), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(), .WAKE_PIN(wake_pin),
      .EDGE_REQUEST_PIN(edge_pin), .PERIPH_REQ(periph_req),
      .INSN_DONE(insn_done), .NEXT_PC(next_pc), .STACK_PTR(stack_ptr),
      .VEC_DATA(vec_data), .RETURN_STB(return_stb),
      .RETURN_CCR_WORD(return_ccr), .MASK(mask), .EXC_BUSY(exc_busy),
      .STACK_WE(stack_we), .STACK_ADDR(stack_addr),
      .STACK_WDATA(stack_wdata), .VEC_RD(vec_rd), .VEC_ADDR(vec_addr),
      .IFETCH(ifetch), .HANDLER_START(handler_start),
      .HANDLER_PC(handler_pc));
   ewic_core_model u_ewic_core_model (.clk(clk), .rst_b(rst_b),
      .exc_busy(exc_busy), .stack_we(stack_we), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .vec_rd(vec_rd), .vec_addr(vec_addr),
      .handler_start(handler_start), .done_dly(done_dly),
      .insn_done(insn_done), .next_pc(next_pc), .stack_ptr(stack_ptr),
      .vec_data(vec_data), .vec_num(vec_num), .pc_seen(pc_seen),
      .lat(lat));
   // ********
   // tasks
   // ********
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wait_rdy(output logic [31:0] r);
      do
         @(posedge clk);
      while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : wait_rdy
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      wait_rdy(r);
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy(r);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rd
   task automatic wait_start();
      int k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (handler_start !== 1'b1 && k < 300);
      chk(handler_start, 32'h1);
      @(posedge clk);
      #1;
   endtask : wait_start
   // ********
   // sequence
   // ********
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: timeout", $time);
         summarize();
      end
   end
   initial
   begin
      {rst_b, hsel, hwrite, return_stb} = 4'h0;
      {haddr, hwdata, htrans, return_ccr, periph_req} = '0;
      hsize    = 3'b010;
      done_dly = 4'h1;
      edge_pin = 5'h1b;
      wake_pin = 8'hfb;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk(mask, 1'b1);
      wr(OFS_PFN_ONE, 32'he);
      wr(OFS_PFN_TWO, 32'h11);
      wr(OFS_EDGE_SEL, 32'h1);
      wr(OFS_PFN_FIVE, 32'hff);
      wr(OFS_WAKE_FLAG, 32'h0);
      rd(OFS_WAKE_FLAG, 32'h4);
      wr(OFS_WAKE_FLAG, 32'h0);
      rd(OFS_WAKE_FLAG, 32'h0);
      rd(OFS_REQ_ONE, 32'h4);
      edge_pin <= 5'h18;
      tick(3);
      rd(OFS_REQ_ONE, 32'h6);
      edge_pin <= 5'h19;
      tick(3);
      rd(OFS_REQ_ONE, 32'h7);
      wr(OFS_REQ_ONE, 32'hfffffff9);
      rd(OFS_REQ_ONE, 32'h1);
      edge_pin   <= 5'h0f;
      wake_pin   <= 8'hdf;
      periph_req <= 20'h80001;
      tick(1);
      periph_req <= 20'h0;
      tick(3);
      rd(OFS_WAKE_FLAG, 32'h20);
      rd(OFS_REQ_ONE, 32'h111);
      rd(OFS_REQ_TWO, 32'h200);
      wr(8'h3c, 32'hffffffff);
      rd(8'h3c, 32'h0);
      wr(OFS_EN_ONE, 32'h11f);
      wr(OFS_EN_TWO, 32'h200);
      chk(exc_busy, 1'b0);
      wr(OFS_CCR, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         if (i == 4)
         begin
            tick(20);
            chk(exc_busy, 1'b0);
            wr(OFS_EN_ONE, 32'h13f);
         end
         wait_start();
         chk(vec_num, 32'(l_vec[i]));
         chk(handler_pc, 32'(16'h4000 + 2 * l_vec[i]));
         chk(lat, 32'd15);
         chk(pc_seen, 32'h1234);
         chk(mask, 1'b1);
         rd(l_ofs[i], l_flag[i]);
         wr(l_ofs[i], l_clr[i]);
         return_stb <= 1'b1;
         done_dly   <= 4'(3 * i + 4);
         tick(1);
         return_stb <= 1'b0;
         tick(2);
      end
      tick(20);
      chk(exc_busy, 1'b0);
      summarize();
   end
endmodule : testbench
`default_nettype wire
